// File: shared/trd_pkg.sv
// constants and state encoding for the tolerance readback target
// assumes one system clock; serial pins already synchronous to it
package trd_pkg;
  // ==========================================
  // memory locations of the tolerance bytes
  localparam logic [4:0] TRD_LOC_TOL_HI = 5'h1e;
  localparam logic [4:0] TRD_LOC_TOL_LO = 5'h1f;
  localparam logic [4:0] TRD_PTR_RST = 5'h00;
  // ==========================================
  // instruction byte fields
  localparam int TRD_CMD_MSB = 7;
  localparam int TRD_CMD_LSB = 5;
  localparam logic [2:0] TRD_CMD_EE_READ = 3'h1;
  // ==========================================
  // bus address and byte framing
  localparam int TRD_ADDR_W = 7;
  localparam logic [4:0] TRD_ADDR_BASE_DEF = 5'h0c;
  localparam logic [6:0] TRD_ADDR_RST = 7'h00;
  localparam logic [3:0] TRD_BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] TRD_UNMAPPED_DATA = 8'h00;
  // ==========================================
  // factory tolerance defaults (plain values)
  localparam logic TRD_TOL_SIGN_DEF = 1'b0;
  localparam logic [6:0] TRD_TOL_INT_DEF = 7'h1c;
  localparam logic [7:0] TRD_TOL_FRAC_DEF = 8'h0f;

  typedef enum logic [2:0] {
    TRD_ST_IDLE = 3'b000,
    TRD_ST_ADDR = 3'b001,
    TRD_ST_ADDR_ACK = 3'b010,
    TRD_ST_INSTR = 3'b011,
    TRD_ST_INSTR_ACK = 3'b100,
    TRD_ST_TX = 3'b101,
    TRD_ST_TX_ACK = 3'b110,
    TRD_ST_SKIP = 3'b111
  } trd_state_e;
endpackage

// File: core/trd_tol_store.sv
// factory tolerance bytes, read-only after production
// assumes pointer comes from the serial target logic
`timescale 1ns/1ns
module trd_tol_store #(
  parameter logic TOL_SIGN = trd_pkg::TRD_TOL_SIGN_DEF,
  parameter logic [6:0] TOL_INT = trd_pkg::TRD_TOL_INT_DEF,
  parameter logic [7:0] TOL_FRAC = trd_pkg::TRD_TOL_FRAC_DEF
) (
  // location select
  input wire logic [4:0] ptr,
  // byte out
  output logic [7:0] data,
  output logic hit
);
  import trd_pkg::*;

  wire sel_hi = (ptr == TRD_LOC_TOL_HI);
  wire sel_lo = (ptr == TRD_LOC_TOL_LO);
  // sign in msb, integer percent below
  wire [7:0] byte_hi = {TOL_SIGN, TOL_INT};
  // fraction, one count per 2^-8 percent
  wire [7:0] byte_lo = TOL_FRAC;

  // constants only, no write path
  assign data = sel_hi ? byte_hi : (sel_lo ? byte_lo : TRD_UNMAPPED_DATA);
  assign hit = sel_hi | sel_lo;
endmodule

// File: core/trd_target.sv
// two-wire serial target serving the tolerance readback
// assumes scl/sda inputs synchronous to clock; sda wired-and outside
//
// Functional notes
// - The tolerance lives in two fixed bytes, sign and integer at 11110 and fraction at 11111.
// - Each tolerance byte can be read alone after its own pointer-setting instruction.
// - In a consecutive read the pointer moves from 11110 to 11111 after the first byte is sent.
// - The first byte carries the sign in bit 7 (one for negative) and the integer percent in bits 6..0.
// - The second byte is the fraction, each count worth two to the minus eight percent.
// - The tolerance bytes are fixed after production and are returned whenever requested.
// - The two address-select pins are sampled once after each reset release into a 7-bit address held until the next reset.
// - Up to four devices share the bus, each answering only its own decoded address.
`timescale 1ns/1ns
module trd_target #(
  parameter logic [4:0] ADDR_BASE = trd_pkg::TRD_ADDR_BASE_DEF,
  parameter logic TOL_SIGN = trd_pkg::TRD_TOL_SIGN_DEF,
  parameter logic [6:0] TOL_INT = trd_pkg::TRD_TOL_INT_DEF,
  parameter logic [7:0] TOL_FRAC = trd_pkg::TRD_TOL_FRAC_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // address straps
  input wire logic addr_select_pin0,
  input wire logic addr_select_pin1,
  // serial bus, sda open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // status
  output logic [trd_pkg::TRD_ADDR_W-1:0] dev_addr,
  output logic addr_valid,
  output logic [4:0] read_ptr
);
  import trd_pkg::*;

  // ==========================================
  // parameter checks
  generate
    if (ADDR_BASE[4:2] == 3'h0 || ADDR_BASE[4:1] == 4'hf) begin : g_bad_base
      $error("address base falls in reserved bus range");
    end
  endgenerate

  // ==========================================
  // registers
  trd_state_e state_reg, state_next;
  logic scl_prev_reg, sda_prev_reg;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [4:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic oe_reg, oe_next;
  logic sda_out_reg;
  logic [6:0] dev_addr_reg;
  logic addr_valid_reg;

  // ==========================================
  // bus event decode
  wire scl_rise = scl_in & ~scl_prev_reg;
  wire scl_fall = ~scl_in & scl_prev_reg;
  wire start_cond = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  wire stop_cond = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
  wire byte_done = (bit_cnt_reg == TRD_BITS_PER_BYTE);
  wire addr_match = addr_valid_reg && (shift_reg[7:1] == dev_addr_reg);
  wire [2:0] instr_cmd = shift_reg[TRD_CMD_MSB:TRD_CMD_LSB];
  wire instr_is_read = (instr_cmd == TRD_CMD_EE_READ);
  wire [7:0] rom_data;
  wire rom_hit;
  wire [4:0] ptr_adv = (ptr_reg == TRD_LOC_TOL_HI) ? TRD_LOC_TOL_LO : ptr_reg;

  trd_tol_store #(
    .TOL_SIGN(TOL_SIGN),
    .TOL_INT(TOL_INT),
    .TOL_FRAC(TOL_FRAC)
  ) u_store (
    .ptr(ptr_reg),
    .data(rom_data),
    .hit(rom_hit)
  );

  // ==========================================
  // strap capture, once after reset release
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dev_addr_reg <= TRD_ADDR_RST;
      addr_valid_reg <= 1'b0;
    end else if (!addr_valid_reg) begin
      dev_addr_reg <= {ADDR_BASE, addr_select_pin1, addr_select_pin0};
      addr_valid_reg <= 1'b1;
    end
  end

  // ==========================================
  // protocol engine
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    oe_next = oe_reg;
    if (scl_rise && state_reg != TRD_ST_IDLE && state_reg != TRD_ST_SKIP) begin
      shift_next = {shift_reg[6:0], sda_in};
      bit_cnt_next = bit_cnt_reg + 4'h1;
    end
    case (state_reg)
      TRD_ST_IDLE, TRD_ST_SKIP: begin
        oe_next = 1'b0;
      end
      TRD_ST_ADDR: begin
        if (scl_fall && byte_done) begin
          if (addr_match) begin
            oe_next = 1'b1;
            rw_next = shift_reg[0];
            state_next = TRD_ST_ADDR_ACK;
          end else begin
            state_next = TRD_ST_SKIP;
          end
        end
      end
      TRD_ST_ADDR_ACK: begin
        if (scl_fall) begin
          bit_cnt_next = 4'h0;
          if (rw_reg) begin
            // first data bit goes out on this edge
            oe_next = ~rom_data[7];
            tx_next = {rom_data[6:0], 1'b0};
            state_next = TRD_ST_TX;
          end else begin
            oe_next = 1'b0;
            state_next = TRD_ST_INSTR;
          end
        end
      end
      TRD_ST_INSTR: begin
        if (scl_fall && byte_done) begin
          oe_next = 1'b1;
          if (instr_is_read) begin
            ptr_next = shift_reg[4:0];
          end
          state_next = TRD_ST_INSTR_ACK;
        end
      end
      TRD_ST_INSTR_ACK: begin
        if (scl_fall) begin
          oe_next = 1'b0;
          state_next = TRD_ST_SKIP;
        end
      end
      TRD_ST_TX: begin
        if (scl_fall) begin
          if (byte_done) begin
            oe_next = 1'b0;
            ptr_next = ptr_adv;
            bit_cnt_next = 4'h0;
            state_next = TRD_ST_TX_ACK;
          end else begin
            oe_next = ~tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
      end
      TRD_ST_TX_ACK: begin
        if (scl_rise) begin
          nack_next = sda_in;
        end
        if (scl_fall) begin
          bit_cnt_next = 4'h0;
          if (nack_reg) begin
            oe_next = 1'b0;
            state_next = TRD_ST_SKIP;
          end else begin
            oe_next = ~rom_data[7];
            tx_next = {rom_data[6:0], 1'b0};
            state_next = TRD_ST_TX;
          end
        end
      end
      default: begin
        state_next = TRD_ST_IDLE;
        oe_next = 1'b0;
      end
    endcase
    // start or repeated start wins over all
    if (start_cond) begin
      state_next = TRD_ST_ADDR;
      bit_cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_cond) begin
      state_next = TRD_ST_IDLE;
      oe_next = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= TRD_ST_IDLE;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= TRD_PTR_RST;
      rw_reg <= 1'b0;
      nack_reg <= 1'b1;
      oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      oe_reg <= oe_next;
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = oe_reg;
  assign dev_addr = dev_addr_reg;
  assign addr_valid = addr_valid_reg;
  assign read_ptr = ptr_reg;

  // ==========================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_tx_byte_end;
    state_reg == TRD_ST_TX && scl_fall && byte_done && !start_cond && !stop_cond;
  endsequence

  sequence s_instr_read_end;
    state_reg == TRD_ST_INSTR && scl_fall && byte_done && instr_is_read && !start_cond && !stop_cond;
  endsequence

  a_ptr_advance: assert property (s_tx_byte_end ##0 (ptr_reg == TRD_LOC_TOL_HI) |=>
    (ptr_reg == TRD_LOC_TOL_LO) && (state_reg == TRD_ST_TX_ACK))
    else $error("pointer did not advance to fraction byte");

  a_hi_byte_fmt: assert property ((ptr_reg == TRD_LOC_TOL_HI) |->
    rom_hit && rom_data[7] == TOL_SIGN && rom_data[6:0] == TOL_INT)
    else $error("sign and integer byte wrong");

  a_lo_byte_fmt: assert property ((ptr_reg == TRD_LOC_TOL_LO) |-> rom_hit && rom_data == TOL_FRAC)
    else $error("fraction byte wrong");

  a_rom_fixed: assert property (state_reg == TRD_ST_ADDR_ACK && rw_reg && scl_fall && !start_cond && !stop_cond |=>
    state_reg == TRD_ST_TX && sda_oe == ~rom_data[7])
    else $error("stored byte not returned on read");

  a_instr_ptr: assert property (s_instr_read_end |=> ptr_reg == $past(shift_reg[4:0]) ##1
    (state_reg == TRD_ST_INSTR_ACK || state_reg == TRD_ST_SKIP || state_reg == TRD_ST_ADDR
     || state_reg == TRD_ST_IDLE))
    else $error("read instruction did not place pointer");

  a_addr_capture: assert property ($rose(addr_valid_reg) |->
    dev_addr_reg == {ADDR_BASE, $past(addr_select_pin1), $past(addr_select_pin0)})
    else $error("strap decode wrong");

  a_addr_hold: assert property (addr_valid_reg |=> addr_valid_reg && $stable(dev_addr_reg))
    else $error("bus address changed after capture");

  a_addr_ignore: assert property ((state_reg == TRD_ST_ADDR && scl_fall && byte_done &&
    shift_reg[7:1] != dev_addr_reg && !start_cond) |=> !sda_oe ##1 !sda_oe)
    else $error("acknowledged a foreign address");
endmodule

// File: tb/trd_bus_ctl.sv
// controller model for the two-wire bus, byte transfers and tolerance reads
// assumes the bench resolves sda with a pull-up from both enables
`timescale 1ns/1ns
module trd_bus_ctl (
  // clock
  input wire logic clock,
  // serial bus
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // ==========================================
  // bus steps, all changes on falling clock
  task automatic hc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // data set mid-low, sampled mid-high
  task automatic bit_x(input logic tx, output logic rx);
    scl = 1'b0;
    hc(3);
    sda_oe = ~tx;
    hc(3);
    scl = 1'b1;
    hc(2);
    rx = sda;
    hc(2);
  endtask
  task automatic start_c();
    scl = 1'b0;
    hc(3);
    sda_oe = 1'b0;
    hc(3);
    scl = 1'b1;
    hc(4);
    sda_oe = 1'b1;
    hc(4);
  endtask
  task automatic stop_c();
    scl = 1'b0;
    hc(3);
    sda_oe = 1'b1;
    hc(3);
    scl = 1'b1;
    hc(4);
    sda_oe = 1'b0;
    hc(4);
  endtask
  // byte msb first, then the ninth clock
  task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ack_tx, ack_rx);
  endtask
  // pointer placement, restart, one or two bytes back
  task automatic tol_read(input logic [6:0] a, input logic [4:0] loc, input logic two,
                          output logic [7:0] b0, output logic [7:0] b1, output logic ok);
    logic [7:0] rx;
    logic k0, k1, k2, k;
    start_c();
    xfer({a, 1'b0}, 1'b1, rx, k0);
    xfer({3'h1, loc}, 1'b1, rx, k1);
    start_c();
    xfer({a, 1'b1}, 1'b1, rx, k2);
    b1 = 8'h00;
    xfer(8'hff, ~two, b0, k);
    if (two) begin
      xfer(8'hff, 1'b1, b1, k);
    end
    stop_c();
    ok = ~(k0 | k1 | k2);
  endtask
endmodule

// File: tb/trd_target_bench.sv
// self-checking bench for the tolerance readback target
// assumes trd_bus_ctl as the only other party on the bus
`timescale 1ns/1ns
module trd_target_bench;
  import trd_pkg::*;
  logic clock, sys_rst, p0, p1, scl, sda, ctl_oe, sda_out, sda_oe, addr_valid, ok, k;
  logic [6:0] dev_addr, own;
  logic [4:0] read_ptr;
  logic [7:0] b0, b1;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  // pull-up wire
  assign sda = ~((sda_oe & ~sda_out) | ctl_oe);
  trd_target #(.TOL_SIGN(1'b1), .TOL_INT(7'h2a), .TOL_FRAC(8'h81)) dut (
    .clock(clock), .sys_rst(sys_rst), .addr_select_pin0(p0), .addr_select_pin1(p1),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .dev_addr(dev_addr), .addr_valid(addr_valid), .read_ptr(read_ptr));
  trd_bus_ctl ctl (.clock(clock), .sda(sda), .scl(scl), .sda_oe(ctl_oe));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ==========================================
  // reporting
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 20000) begin
      num_errors++;
      $display("[ERR] %0t run too long", $time);
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic reset_with(input logic [1:0] s);
    sys_rst = 1'b1;
    {p1, p0} = s;
    repeat (8) @(negedge clock);
    chk({1'b0, sda_oe, addr_valid, read_ptr}, 8'h00);
    chk({1'b0, dev_addr}, 8'h00);
    sys_rst = 1'b0;
    repeat (2) @(negedge clock);
    own = {TRD_ADDR_BASE_DEF, s};
  endtask
  task automatic t_straps();
    for (int s = 0; s < 4; s++) begin
      reset_with(s[1:0]);
      chk({addr_valid, dev_addr}, {1'b1, TRD_ADDR_BASE_DEF, s[1:0]});
      {p1, p0} = ~s[1:0];
      ctl.tol_read(own, TRD_LOC_TOL_HI, 1'b0, b0, b1, ok);
      chk({1'b0, dev_addr}, {1'b0, own});
      chk({ok, b0}, {1'b1, 8'haa});
      ctl.tol_read(own ^ 7'h01, TRD_LOC_TOL_HI, 1'b0, b0, b1, ok);
      chk({7'h0, ok}, 8'h00);
    end
  endtask
  task automatic t_single();
    ctl.tol_read(own, TRD_LOC_TOL_HI, 1'b0, b0, b1, ok);
    chk({ok, b0}, {1'b1, 8'haa});
    ctl.tol_read(own, TRD_LOC_TOL_LO, 1'b0, b0, b1, ok);
    chk({ok, b0}, {1'b1, 8'h81});
    // location outside the two tolerance bytes
    ctl.tol_read(own, 5'h00, 1'b0, b0, b1, ok);
    chk({ok, b0}, {1'b1, TRD_UNMAPPED_DATA});
  endtask
  task automatic t_consec();
    ctl.tol_read(own, TRD_LOC_TOL_HI, 1'b1, b0, b1, ok);
    chk({ok, b0}, {1'b1, 8'haa});
    chk(b1, 8'h81);
    chk({3'h0, read_ptr}, {3'h0, TRD_LOC_TOL_LO});
  endtask
  // write attempt must leave the stored byte alone
  task automatic t_write();
    ctl.start_c();
    ctl.xfer({own, 1'b0}, 1'b1, b1, k);
    ctl.xfer({3'h1, TRD_LOC_TOL_HI}, 1'b1, b1, k);
    ctl.xfer(8'h55, 1'b1, b1, k);
    chk({7'h0, k}, 8'h01);
    ctl.stop_c();
    // other command: acknowledged, pointer left alone
    ctl.start_c();
    ctl.xfer({own, 1'b0}, 1'b1, b1, k);
    ctl.xfer({3'h2, TRD_LOC_TOL_LO}, 1'b1, b1, k);
    ctl.stop_c();
    chk({k, 2'h0, read_ptr}, {3'h0, TRD_LOC_TOL_HI});
    ctl.tol_read(own, TRD_LOC_TOL_HI, 1'b0, b0, b1, ok);
    chk({ok, b0}, {1'b1, 8'haa});
  endtask
  initial begin
    sys_rst = 1'b1;
    p0 = 1'b0;
    p1 = 1'b0;
    @(negedge clock);
    t_straps();
    t_single();
    t_consec();
    t_write();
    conclude();
  end
endmodule
